// ### rtl/gmb_depth_decode.sv
`timescale 1ns/100ps
module gmb_depth_decode
	import gmb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// raw element
	input  wire logic        valid_i,
	input  wire gmb_fmt_t    fmt_i,
	input  wire logic [63:0] data_i,
	// decoded pixel
	output logic             valid_o,
	output gmb_pix_t         pix_o
);

	typedef struct packed {
		logic     valid;
		gmb_pix_t pix;
	} gmb_dec_state_t;

	gmb_dec_state_t st_r;
	gmb_dec_state_t st_nxt;

	always_comb begin
		st_nxt       = st_r;
		st_nxt.valid = valid_i;
		if (valid_i) begin
			st_nxt.pix = '0;
			unique case (fmt_i)
				GMB_FMT_FLOAT_DEPTH_WITH_STENCIL_64: begin
					st_nxt.pix.depth_float = data_i[31:0]; // RULE14
					st_nxt.pix.stencil     = data_i[39:32]; // RULE14
					st_nxt.pix.has_stencil = 1'b1;
					st_nxt.pix.is_float    = 1'b1;
				end
				GMB_FMT_FLOAT_DEPTH_32: begin
					st_nxt.pix.depth_float = data_i[31:0]; // RULE14
					st_nxt.pix.is_float    = 1'b1;
				end
				GMB_FMT_FIXED_DEPTH24_STENCIL8: begin
					st_nxt.pix.depth_fixed = data_i[23:0]; // RULE15
					st_nxt.pix.stencil     = data_i[31:24]; // RULE15
					st_nxt.pix.has_stencil = 1'b1;
				end
				GMB_FMT_FIXED_DEPTH_16: begin
					st_nxt.pix.depth_fixed = {data_i[15:0], 8'h00}; // RULE16
				end
				GMB_FMT_STENCIL_ONLY_8: begin
					st_nxt.pix.stencil     = data_i[7:0]; // RULE17
					st_nxt.pix.has_stencil = 1'b1;
				end
				default: st_nxt.pix = '0;
			endcase
		end
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign valid_o = st_r.valid;
	assign pix_o   = st_r.pix;

endmodule : gmb_depth_decode

// ### rtl/gmb_pkg.sv
package gmb_pkg;

	////////////////////////////////////////////////////////////////////////
	// sizes and alignments
	localparam int          GMB_AW            = 32;
	localparam logic [11:0] GMB_PAGE_MASK     = 12'hfff;
	localparam logic [2:0]  GMB_QW_MASK       = 3'h7;
	localparam logic [4:0]  GMB_PITCH_MASK    = 5'h1f;
	localparam logic [32:0] GMB_RING_MAX_LEN  = 33'h000200000;
	localparam logic [2:0]  GMB_STENCIL_BYTES = 3'h1;

	////////////////////////////////////////////////////////////////////////
	// depth formats
	typedef enum logic [2:0] {
		GMB_FMT_FLOAT_DEPTH_WITH_STENCIL_64,
		GMB_FMT_FLOAT_DEPTH_32,
		GMB_FMT_FIXED_DEPTH24_STENCIL8,
		GMB_FMT_FIXED_DEPTH_16,
		GMB_FMT_STENCIL_ONLY_8
	} gmb_fmt_t;

	////////////////////////////////////////////////////////////////////////
	// request carriers
	typedef struct packed {
		logic [31:0] status_page_address_reg;
		logic [31:0] ring_base;
		logic [32:0] ring_len;
		logic [31:0] batch_start;
		logic [31:0] batch_end;
		logic        colour_tiled;
		logic        depth_tiled;
		logic        colour_walk_y;
		logic        depth_walk_y;
		logic [31:0] colour_base;
		logic [31:0] depth_base;
		logic [15:0] colour_pitch;
		logic [15:0] depth_pitch;
		logic        depth_present;
		logic        depth_test_en;
		logic        stencil_test_en;
	} gmb_cfg_t;

	typedef struct packed {
		logic        err_status;
		logic        err_ring;
		logic        err_batch;
		logic        err_tile;
		logic        err_pitch;
		logic        err_coalign;
		logic        err_depth_missing;
	} gmb_err_t;

	typedef struct packed {
		logic [23:0] depth_fixed;
		logic [31:0] depth_float;
		logic [7:0]  stencil;
		logic        has_stencil;
		logic        is_float;
	} gmb_pix_t;

endpackage : gmb_pkg

// ### rtl/gmb_placement_check.sv
`timescale 1ns/100ps
// Functional notes
// RULE1: status written to aligned 4KB snooped page
// RULE2: ring starts 4KB aligned, linear memory
// RULE3: ring length at most 2MB
// RULE4: batch quadword aligned, whole quadwords long
// RULE5: batch end is last valid quadword
// RULE6: batch fetches never snoop processor cache
// RULE7: batch length up to full 4GB
// RULE8: software invalidates texture cache after blits
// RULE9: monochrome source bits expand to colour depth
// RULE10: pattern surfaces need invalidate, treat read-only
// RULE11: tiled colour and depth share walk
// RULE12: linear pitches multiples of 32 bytes
// RULE13: linear colour, depth co-aligned in 32 bytes
// RULE14: float depth first dword, stencil next byte
// RULE15: fixed depth low three bytes, stencil top
// RULE16: 16-bit element is one unorm depth
// RULE17: separate stencil one byte per pixel
// RULE18: depth buffer needed only for real tests
// RULE19: violations flag error and block fetching
module gmb_placement_check
	import gmb_pkg::*;
(
	// clock and reset
	input  wire logic        clk_sys_i,
	input  wire logic        nrst_i,
	// configuration
	input  wire logic        check_i,
	input  wire gmb_cfg_t    cfg_i,
	// status write request
	input  wire logic        status_req_i,
	input  wire logic [11:0] status_off_i,
	input  wire logic [31:0] status_data_i,
	// batch fetch control
	input  wire logic        batch_go_i,
	input  wire logic        fetch_ready_i,
	// monochrome expansion
	input  wire logic        mono_valid_i,
	input  wire logic        mono_bit_i,
	input  wire logic [31:0] mono_fg_i,
	input  wire logic [31:0] mono_bg_i,
	// depth element decode
	input  wire logic        depth_valid_i,
	input  wire gmb_fmt_t    depth_fmt_i,
	input  wire logic [63:0] depth_data_i,
	// errors
	output gmb_err_t         err_o,
	output logic             err_any_o,
	output logic             cfg_ok_o,
	// status write out
	output logic             status_wr_o,
	output logic [31:0]      status_addr_o,
	output logic [31:0]      status_data_o,
	output logic             status_snoop_o,
	// batch fetch out
	output logic             fetch_valid_o,
	output logic [31:0]      fetch_addr_o,
	output logic             fetch_snoop_o,
	output logic             batch_busy_o,
	output logic             batch_done_o,
	// expanded pixel
	output logic             mono_valid_o,
	output logic [31:0]      mono_pix_o,
	// decoded depth
	output logic             depth_valid_o,
	output gmb_pix_t         depth_pix_o,
	output logic             depth_needed_o
);

	typedef enum logic [1:0] {
		GMB_ST_IDLE,
		GMB_ST_FETCH,
		GMB_ST_DONE
	} gmb_bstate_t;

	typedef struct packed {
		gmb_bstate_t bst;
		gmb_err_t    err;
		logic        ok;
		logic [31:0] fptr;
		logic        done;
		logic        swr;
		logic [31:0] saddr;
		logic [31:0] sdata;
		logic        mval;
		logic [31:0] mpix;
	} gmb_state_t;

	gmb_state_t st_r;
	gmb_state_t st_nxt;
	gmb_err_t   chk;
	logic       both_linear;

	////////////////////////////////////////////////////////////////////////
	// placement checks
	always_comb begin
		both_linear = !cfg_i.colour_tiled && !cfg_i.depth_tiled
			&& cfg_i.depth_present;
		chk = '0;
		chk.err_status = |(cfg_i.status_page_address_reg[11:0]
			& GMB_PAGE_MASK); // RULE1
		chk.err_ring = (|(cfg_i.ring_base[11:0] & GMB_PAGE_MASK)) // RULE2
			|| (cfg_i.ring_len > GMB_RING_MAX_LEN); // RULE3
		chk.err_batch = (|(cfg_i.batch_start[2:0] & GMB_QW_MASK)) // RULE4
			|| (|(cfg_i.batch_end[2:0] & GMB_QW_MASK)) // RULE5
			|| (cfg_i.batch_end < cfg_i.batch_start);
		chk.err_tile = cfg_i.colour_tiled && cfg_i.depth_tiled
			&& cfg_i.depth_present
			&& (cfg_i.colour_walk_y != cfg_i.depth_walk_y); // RULE11
		chk.err_pitch = both_linear
			&& ((|(cfg_i.colour_pitch[4:0] & GMB_PITCH_MASK))
			|| (|(cfg_i.depth_pitch[4:0] & GMB_PITCH_MASK))); // RULE12
		chk.err_coalign = both_linear
			&& ((cfg_i.colour_base[4:0] & GMB_PITCH_MASK)
			!= (cfg_i.depth_base[4:0] & GMB_PITCH_MASK)); // RULE13
		chk.err_depth_missing = !cfg_i.depth_present
			&& (cfg_i.depth_test_en || cfg_i.stencil_test_en); // RULE18
	end

	////////////////////////////////////////////////////////////////////////
	// next state
	always_comb begin
		st_nxt      = st_r;
		st_nxt.done = 1'b0;
		st_nxt.swr  = 1'b0;
		st_nxt.mval = mono_valid_i;
		if (check_i) begin
			st_nxt.err = chk; // RULE19
			st_nxt.ok  = !(|chk);
		end
		if (status_req_i && st_r.ok) begin
			st_nxt.swr   = 1'b1; // RULE1
			st_nxt.saddr = {cfg_i.status_page_address_reg[31:12],
				status_off_i[11:2], 2'b00};
			st_nxt.sdata = status_data_i;
		end
		if (mono_valid_i) begin
			st_nxt.mpix = mono_bit_i ? mono_fg_i : mono_bg_i; // RULE9
		end
		unique case (st_r.bst)
			GMB_ST_IDLE: begin
				if (batch_go_i && st_r.ok && !check_i) begin // RULE19
					st_nxt.fptr = cfg_i.batch_start;
					st_nxt.bst  = GMB_ST_FETCH;
				end
			end
			GMB_ST_FETCH: begin
				if (fetch_ready_i) begin
					if (st_r.fptr == cfg_i.batch_end) begin // RULE5
						st_nxt.bst  = GMB_ST_DONE;
					end else begin
						st_nxt.fptr = st_r.fptr + 32'h8; // RULE7
					end
				end
			end
			GMB_ST_DONE: begin
				st_nxt.done = 1'b1;
				st_nxt.bst  = GMB_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// depth element decode
	gmb_depth_decode u_dec (
		.clk_sys_i (clk_sys_i),
		.nrst_i    (nrst_i),
		.valid_i   (depth_valid_i),
		.fmt_i     (depth_fmt_i),
		.data_i    (depth_data_i),
		.valid_o   (depth_valid_o),
		.pix_o     (depth_pix_o)
	);

	////////////////////////////////////////////////////////////////////////
	// outputs
	assign err_o          = st_r.err;
	assign err_any_o      = |st_r.err;
	assign cfg_ok_o       = st_r.ok;
	assign status_wr_o    = st_r.swr;
	assign status_addr_o  = st_r.saddr;
	assign status_data_o  = st_r.sdata;
	assign status_snoop_o = 1'b1; // RULE1
	assign fetch_valid_o  = (st_r.bst == GMB_ST_FETCH);
	assign fetch_addr_o   = st_r.fptr;
	assign fetch_snoop_o  = 1'b0; // RULE6
	assign batch_busy_o   = (st_r.bst != GMB_ST_IDLE);
	assign batch_done_o   = st_r.done;
	assign mono_valid_o   = st_r.mval;
	assign mono_pix_o     = st_r.mpix;
	assign depth_needed_o = cfg_i.depth_test_en
		|| cfg_i.stencil_test_en; // RULE18

endmodule : gmb_placement_check

// ### tb/gmb_mem_model.sv
`timescale 1ns/100ps
module gmb_mem_model (
	// clock and reset
	input  wire logic clk_sys_i,
	input  wire logic nrst_i,
	// fetch handshake
	input  wire logic fetch_valid_i,
	input  wire logic slow_i,
	output logic      fetch_ready_o
);
	logic phase_r;
	always_ff @(posedge clk_sys_i or negedge nrst_i) begin
		if (!nrst_i)
			phase_r <= 1'b0;
		else
			phase_r <= ~phase_r;
	end
	// unsnooped memory, stalls every other cycle when slow
	assign fetch_ready_o = fetch_valid_i && (!slow_i || phase_r);
endmodule : gmb_mem_model

// ### tb/gmb_placement_check_properties.sv
`timescale 1ns/100ps
module gmb_placement_check_props
	import gmb_pkg::*;
(
	// clock and reset
	input wire logic        clk_sys_i,
	input wire logic        nrst_i,
	// stimulus side
	input wire logic        check_i,
	input wire gmb_cfg_t    cfg_i,
	input wire logic        status_req_i,
	input wire logic        batch_go_i,
	input wire logic        fetch_ready_i,
	// design side
	input wire gmb_err_t    err_o,
	input wire logic        cfg_ok_o,
	input wire logic        status_wr_o,
	input wire logic [31:0] status_addr_o,
	input wire logic        status_snoop_o,
	input wire logic        fetch_valid_o,
	input wire logic [31:0] fetch_addr_o,
	input wire logic        fetch_snoop_o,
	input wire logic        batch_busy_o,
	input wire logic        batch_done_o
);
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!nrst_i);
	AST_SNOOP: assert property (status_snoop_o && !fetch_snoop_o)
		else $error("snoop attribute wrong");
	AST_PAGE: assert property (status_req_i && cfg_ok_o |=> status_wr_o &&
		status_addr_o[31:12] == cfg_i.status_page_address_reg[31:12])
		else $error("status write outside page");
	AST_STEP: assert property (fetch_valid_o && fetch_ready_i &&
		fetch_addr_o != cfg_i.batch_end |=> fetch_valid_o &&
		fetch_addr_o == $past(fetch_addr_o) + 32'h8)
		else $error("fetch step wrong");
	AST_END: assert property (fetch_valid_o && fetch_ready_i &&
		fetch_addr_o == cfg_i.batch_end |=> !fetch_valid_o ##1 batch_done_o)
		else $error("fetch end wrong");
	AST_HOLD: assert property (fetch_valid_o && !fetch_ready_i |=>
		fetch_valid_o && $stable(fetch_addr_o))
		else $error("fetch not held");
	AST_BLOCK: assert property (batch_go_i && !cfg_ok_o && !batch_busy_o |=>
		!fetch_valid_o)
		else $error("fetch from bad config");
	AST_RING: assert property (check_i && cfg_i.ring_len > GMB_RING_MAX_LEN
		|=> err_o.err_ring && !cfg_ok_o)
		else $error("ring length not flagged");
	AST_ERROK: assert property (check_i |=> (err_o == '0) == cfg_ok_o)
		else $error("ok and error disagree");
	C_DONE: cover property (batch_done_o);
	C_RING: cover property (err_o.err_ring);
	C_STAT: cover property (status_wr_o);
endmodule : gmb_placement_check_props

bind gmb_placement_check gmb_placement_check_props u_props (
	.clk_sys_i      (clk_sys_i),
	.nrst_i         (nrst_i),
	.check_i        (check_i),
	.cfg_i          (cfg_i),
	.status_req_i   (status_req_i),
	.batch_go_i     (batch_go_i),
	.fetch_ready_i  (fetch_ready_i),
	.err_o          (err_o),
	.cfg_ok_o       (cfg_ok_o),
	.status_wr_o    (status_wr_o),
	.status_addr_o  (status_addr_o),
	.status_snoop_o (status_snoop_o),
	.fetch_valid_o  (fetch_valid_o),
	.fetch_addr_o   (fetch_addr_o),
	.fetch_snoop_o  (fetch_snoop_o),
	.batch_busy_o   (batch_busy_o),
	.batch_done_o   (batch_done_o)
);

// ### tb/gmb_placement_check_tb.sv
`timescale 1ns/100ps
module gmb_placement_check_tb import gmb_pkg::*;;
	logic        clk_sys_i = 0, nrst_i = 0, check_i = 0, status_req_i = 0;
	logic        batch_go_i = 0, mono_valid_i = 0, mono_bit_i = 0, slow = 0;
	logic        depth_valid_i = 0, fetch_ready_i;
	logic [11:0] status_off_i = 0;
	logic [31:0] status_data_i = 0, mono_fg_i = 0, mono_bg_i = 0;
	logic [63:0] depth_data_i = 64'h1122334455667788;
	gmb_cfg_t    cfg_i, g;
	gmb_fmt_t    depth_fmt_i;
	gmb_err_t    err_o;
	gmb_pix_t    depth_pix_o;
	logic        err_any_o, cfg_ok_o, status_wr_o, status_snoop_o;
	logic        fetch_valid_o, fetch_snoop_o, batch_busy_o, batch_done_o;
	logic        mono_valid_o, depth_valid_o, depth_needed_o;
	logic [31:0] status_addr_o, status_data_o, fetch_addr_o, mono_pix_o;
	int          failures = 0, n_tests = 0;

	gmb_placement_check dut (
		.clk_sys_i      (clk_sys_i),
		.nrst_i         (nrst_i),
		.check_i        (check_i),
		.cfg_i          (cfg_i),
		.status_req_i   (status_req_i),
		.status_off_i   (status_off_i),
		.status_data_i  (status_data_i),
		.batch_go_i     (batch_go_i),
		.fetch_ready_i  (fetch_ready_i),
		.mono_valid_i   (mono_valid_i),
		.mono_bit_i     (mono_bit_i),
		.mono_fg_i      (mono_fg_i),
		.mono_bg_i      (mono_bg_i),
		.depth_valid_i  (depth_valid_i),
		.depth_fmt_i    (depth_fmt_i),
		.depth_data_i   (depth_data_i),
		.err_o          (err_o),
		.err_any_o      (err_any_o),
		.cfg_ok_o       (cfg_ok_o),
		.status_wr_o    (status_wr_o),
		.status_addr_o  (status_addr_o),
		.status_data_o  (status_data_o),
		.status_snoop_o (status_snoop_o),
		.fetch_valid_o  (fetch_valid_o),
		.fetch_addr_o   (fetch_addr_o),
		.fetch_snoop_o  (fetch_snoop_o),
		.batch_busy_o   (batch_busy_o),
		.batch_done_o   (batch_done_o),
		.mono_valid_o   (mono_valid_o),
		.mono_pix_o     (mono_pix_o),
		.depth_valid_o  (depth_valid_o),
		.depth_pix_o    (depth_pix_o),
		.depth_needed_o (depth_needed_o)
	);
	gmb_mem_model u_mem (.clk_sys_i(clk_sys_i), .nrst_i(nrst_i),
		.fetch_valid_i(fetch_valid_o), .slow_i(slow),
		.fetch_ready_o(fetch_ready_i));

	always #12.5 clk_sys_i = ~clk_sys_i;

	////////////////////////////////////////////////////////////////////////
	task tk;
		@(posedge clk_sys_i);
		#1;
	endtask : tk

	task ck(input string n, input logic [63:0] e, input logic [63:0] v);
		n_tests++;
		if (v !== e) begin
			failures++;
			$display("[ERR] %s exp %h got %h", n, e, v);
		end
	endtask : ck

	task report_and_stop;
		if (failures == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : report_and_stop

	task run(input gmb_cfg_t c, input logic [6:0] e);
		cfg_i = c;
		check_i = 1;
		tk;
		check_i = 0;
		ck("err", e, err_o);
		ck("ok", e == 7'h0, cfg_ok_o);
		ck("any", e != 7'h0, err_any_o);
		tk;
	endtask : run

	////////////////////////////////////////////////////////////////////////
	task t_place;
		gmb_cfg_t c;
		c = g;
		c.ring_len = 33'h000200000;
		run(c, 7'h00);
		ck("need1", 1, depth_needed_o);
		c.ring_len = 33'h000200001;
		run(c, 7'h20);
		c = g;
		c.ring_base = 32'h00001800;
		run(c, 7'h20);
		c = g;
		c.batch_start = 32'h00000104;
		run(c, 7'h10);
		c = g;
		c.batch_end = 32'h0000011c;
		run(c, 7'h10);
		c = g;
		c.batch_start = 32'h00000120;
		run(c, 7'h10);
		c = g;
		c.batch_end = 32'hfffffff8;
		run(c, 7'h00);
		c = g;
		c.colour_tiled = 1;
		c.depth_tiled = 1;
		c.depth_walk_y = 1;
		run(c, 7'h08);
		c.colour_walk_y = 1;
		run(c, 7'h00);
		c = g;
		c.depth_pitch = 16'h0030;
		run(c, 7'h04);
		c = g;
		c.colour_pitch = 16'h0048;
		run(c, 7'h04);
		c = g;
		c.depth_base = 32'h50000008;
		run(c, 7'h02);
		c = g;
		c.depth_present = 0;
		run(c, 7'h01);
		c.depth_test_en = 0;
		c.stencil_test_en = 0;
		run(c, 7'h00);
		ck("need", 0, depth_needed_o);
	endtask : t_place

	task t_status;
		gmb_cfg_t c;
		run(g, 7'h00);
		status_off_i = 12'h0a4;
		status_data_i = 32'h5a5a0001;
		status_req_i = 1;
		tk;
		status_req_i = 0;
		ck("swr", 1, status_wr_o);
		ck("sadr", 32'h001000a4, status_addr_o);
		ck("sdat", 32'h5a5a0001, status_data_o);
		c = g;
		c.status_page_address_reg = 32'h00100800;
		run(c, 7'h40);
		status_req_i = 1;
		batch_go_i = 1;
		tk;
		status_req_i = 0;
		batch_go_i = 0;
		ck("swr0", 0, status_wr_o);
		ck("fv0", 0, fetch_valid_o);
	endtask : t_status

	task t_fetch(input logic s);
		int n;
		n = 0;
		slow = s;
		run(g, 7'h00);
		batch_go_i = 1;
		tk;
		batch_go_i = 0;
		ck("busy", 1, batch_busy_o);
		for (int i = 0; i < 40 && batch_done_o !== 1'b1; i++) begin
			if (fetch_valid_o && fetch_ready_i) begin
				ck("addr", g.batch_start + n * 8, fetch_addr_o);
				n++;
			end
			ck("snp", 0, fetch_snoop_o);
			tk;
		end
		ck("cnt", 4, n);
		ck("done", 1, batch_done_o);
		ck("idle", 0, batch_busy_o);
		if (batch_done_o !== 1'b1)
			report_and_stop;
	endtask : t_fetch

	task dp(input gmb_fmt_t f, input logic [31:0] d, input logic [7:0] s,
		input logic [1:0] hf);
		depth_fmt_i = f;
		depth_valid_i = 1;
		tk;
		ck("dv", 1, depth_valid_o);
		ck("kind", hf, {depth_pix_o.has_stencil, depth_pix_o.is_float});
		if (hf[0])
			ck("dfl", d, depth_pix_o.depth_float);
		else if (f != GMB_FMT_STENCIL_ONLY_8)
			ck("dfx", d[23:0], depth_pix_o.depth_fixed);
		if (hf[1])
			ck("st", s, depth_pix_o.stencil);
	endtask : dp

	task t_pix;
		dp(GMB_FMT_FLOAT_DEPTH_WITH_STENCIL_64, 32'h55667788, 8'h44, 2'h3);
		dp(GMB_FMT_FLOAT_DEPTH_32, 32'h55667788, 8'h00, 2'h1);
		dp(GMB_FMT_FIXED_DEPTH24_STENCIL8, 32'h00667788, 8'h55, 2'h2);
		dp(GMB_FMT_FIXED_DEPTH_16, 32'h00778800, 8'h00, 2'h0);
		dp(GMB_FMT_STENCIL_ONLY_8, 32'h0, 8'h88, 2'h2);
		depth_valid_i = 0;
		mono_fg_i = 32'hffeedd01;
		mono_bg_i = 32'h00112233;
		mono_valid_i = 1;
		mono_bit_i = 1;
		tk;
		ck("mv", 1, mono_valid_o);
		ck("fg", 32'hffeedd01, mono_pix_o);
		mono_bit_i = 0;
		tk;
		ck("bg", 32'h00112233, mono_pix_o);
		mono_valid_i = 0;
		tk;
		ck("mv0", 0, mono_valid_o);
	endtask : t_pix

	////////////////////////////////////////////////////////////////////////
	initial begin
		depth_fmt_i = GMB_FMT_FLOAT_DEPTH_32;
		g = '{status_page_address_reg: 32'h00100000, ring_base: 32'h00002000,
			ring_len: 33'h000001000, batch_start: 32'h00000100,
			batch_end: 32'h00000118, colour_base: 32'h40000000,
			depth_base: 32'h50000000, colour_pitch: 16'h0040,
			depth_pitch: 16'h0060, depth_present: 1'b1, depth_test_en: 1'b1,
			stencil_test_en: 1'b1, default: '0};
		cfg_i = g;
		repeat (8) @(posedge clk_sys_i);
		#1;
		nrst_i = 1;
		t_place;
		t_status;
		t_fetch(0);
		t_fetch(1);
		t_pix;
		report_and_stop;
	end
endmodule : gmb_placement_check_tb
